// ===== hdl/hcdr_regs.sv
/*
 * Configuration and DMA register group: identity, scratch, software reset,
 * mode bits and DMA configuration, plus the burst engine and its FIFO.
 * Assumes a synchronous register port on REF_CLK and external DMA pins.
 */
// How it works
// - Identity word reads version in high half, chip code in low half; writes ignored.
// - Scratch word resets to zero and reads back exactly what was written.
// - Writing one to bit 1 of reset register resets controller registers below 300h.
// - Writing one to bit 0 resets every register of controller and processor side.
// - Bits 31 to 8 give the byte count; transfer rounds it up to whole beats of the bus width.
// - Bytes per beat follow bus width, so burst count differs for 16 and 32 bits.
// - Burst field picks single, 4, 8 or 16 beats per request.
// - Bit 0 zero moves data into internal RAM; one reads it out.
// - Mode bit 8 picks 16-bit bus at zero, 32-bit at one; resets to 32-bit.
// - Mode bits set request and acknowledge polarity; one is active high.
`include "hcdr_defines.svh"
`default_nettype none

module hcdr_regs #(
    parameter logic [15:0] HW_VERSION = 16'h00A1,  // Arbitrary value.
    parameter logic [15:0] CHIP_CODE = 16'h5A3C    // Arbitrary value.
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [`HCDR_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    // Reset pulses to the other register groups
    output logic HC_REG_RESET,
    output logic ALL_REG_RESET,
    // DMA pins
    output logic TRANSFER_REQUEST_LINE,
    input wire logic TRANSFER_ACKNOWLEDGE_LINE,
    input wire logic [31:0] DMA_DATA_IN,
    output logic [31:0] DMA_DATA_OUT,
    output logic DMA_DATA_OE,
    // Internal RAM stream
    output logic RAM_WR_VALID,
    input wire logic RAM_WR_READY,
    output logic [31:0] RAM_WR_DATA,
    output logic RAM_RD_REQ,
    input wire logic RAM_RD_VALID,
    input wire logic [31:0] RAM_RD_DATA,
    // Status
    output logic DMA_BUSY,
    output logic DMA_DONE
);

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    hcdr_pkg::hcdr_mode_t mode;
    hcdr_pkg::hcdr_dma_cfg_t cfg;
    hcdr_pkg::hcdr_dma_cfg_t wcfg;
    hcdr_pkg::hcdr_state_t state;
    logic [31:0] scratch;
    logic soft_all;
    logic wr_mode;
    logic wr_scr;
    logic wr_rst;
    logic wr_cfg;
    logic done;

    assign wcfg = REG_WDATA;
    assign wr_mode = REG_WR && (REG_ADDR == `HCDR_OFS_MODE);
    assign wr_scr = REG_WR && (REG_ADDR == `HCDR_OFS_SCRATCH);
    assign wr_rst = REG_WR && (REG_ADDR == `HCDR_OFS_SWRST);
    assign wr_cfg = REG_WR && (REG_ADDR == `HCDR_OFS_DMACFG);

    // Reset requests act one cycle after the write, so the write itself completes.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            soft_all <= 1'b0;
            HC_REG_RESET <= 1'b0;
            ALL_REG_RESET <= 1'b0;
        end else begin
            soft_all <= wr_rst && REG_WDATA[`HCDR_SWRST_ALL_BIT];
            ALL_REG_RESET <= wr_rst && REG_WDATA[`HCDR_SWRST_ALL_BIT];
            HC_REG_RESET <= wr_rst && (REG_WDATA[`HCDR_SWRST_HC_BIT]
                || REG_WDATA[`HCDR_SWRST_ALL_BIT]);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode <= {1'b1, 1'b0, 1'b0};
        end else if (soft_all) begin
            mode <= {1'b1, 1'b0, 1'b0};
        end else if (wr_mode) begin
            mode <= {REG_WDATA[`HCDR_MODE_BUS32_BIT], REG_WDATA[`HCDR_MODE_ACKPOL_BIT],
                REG_WDATA[`HCDR_MODE_REQPOL_BIT]};
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scratch <= `HCDR_SCRATCH_RESET;
        end else if (soft_all) begin
            scratch <= `HCDR_SCRATCH_RESET;
        end else if (wr_scr) begin
            scratch <= REG_WDATA;
        end
    end

    // A software write beats the hardware clear of the enable bit at completion.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg <= `HCDR_DMACFG_RESET;
        end else if (soft_all) begin
            cfg <= `HCDR_DMACFG_RESET;
        end else if (wr_cfg) begin
            cfg <= {wcfg.byte_count, 4'h0, wcfg.burst_size_sel, wcfg.enable,
                wcfg.read_sel};
        end else if (done) begin
            cfg.enable <= 1'b0;
        end
    end

    // Reserved bits and the self-clearing reset word read as zero.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h0000_0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    `HCDR_OFS_MODE: REG_RDATA <= (32'(mode.bus32) << `HCDR_MODE_BUS32_BIT)
                        | (32'(mode.acknowledge_polarity) << `HCDR_MODE_ACKPOL_BIT)
                        | (32'(mode.request_polarity) << `HCDR_MODE_REQPOL_BIT);
                    `HCDR_OFS_IDENT: REG_RDATA <= {HW_VERSION, CHIP_CODE};
                    `HCDR_OFS_SCRATCH: REG_RDATA <= scratch;
                    `HCDR_OFS_DMACFG: REG_RDATA <= cfg;
                    default: REG_RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and acknowledge edge
    logic ack_s1;
    logic ack_s2;
    logic ack_prev;
    logic [31:0] din_s1;
    logic [31:0] din_s2;
    logic ack_act;
    logic beat;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            // The pin idles high under the reset polarity, so no false edge follows reset.
            ack_s1 <= 1'b1;
            ack_s2 <= 1'b1;
            ack_prev <= 1'b0;
            din_s1 <= 32'h0000_0000;
            din_s2 <= 32'h0000_0000;
        end else begin
            ack_s1 <= TRANSFER_ACKNOWLEDGE_LINE;
            ack_s2 <= ack_s1;
            ack_prev <= ack_act;
            din_s1 <= DMA_DATA_IN;
            din_s2 <= din_s1;
        end
    end

    assign ack_act = ~(ack_s2 ^ mode.acknowledge_polarity);
    assign beat = ack_act && !ack_prev && (state == hcdr_pkg::ST_BURST);

    ////////////////////////////////////////////////////////////////////////////
    // Burst engine
    logic active;
    logic [23:0] beats_left;
    logic [23:0] fetch_left;
    logic [4:0] burst_left;
    logic [4:0] burst_beats;
    logic [4:0] need;
    logic [23:0] next_beats;
    logic burst_ok;
    logic rd_pending;
    logic flush;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [`HCDR_LEVEL_W-1:0] level;

    always_comb begin
        unique case (cfg.burst_size_sel)
            hcdr_pkg::BURST_SINGLE: burst_beats = `HCDR_BEATS_SINGLE;
            hcdr_pkg::BURST_4: burst_beats = `HCDR_BEATS_4;
            hcdr_pkg::BURST_8: burst_beats = `HCDR_BEATS_8;
            hcdr_pkg::BURST_16: burst_beats = `HCDR_BEATS_16;
        endcase
    end

    // A partial last beat still counts as a beat; its unused bytes are don't-care.
    assign next_beats = mode.bus32 ? 24'((25'(wcfg.byte_count) + 25'h3) >> 2)
        : 24'((25'(wcfg.byte_count) + 25'h1) >> 1);
    assign need = (beats_left < 24'(burst_beats)) ? beats_left[4:0] : burst_beats;
    // Inbound bursts wait for room for the whole burst, outbound for all its words.
    assign burst_ok = cfg.read_sel ? (level >= need)
        : ((6'(level) + 6'(need)) <= 6'(`HCDR_FIFO_DEPTH));
    assign done = active && (beats_left == 24'h0) && (state == hcdr_pkg::ST_IDLE)
        && (cfg.read_sel || (!fifo_out_valid && !RAM_WR_VALID));
    assign flush = soft_all || (wr_cfg && !wcfg.enable);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            active <= 1'b0;
            beats_left <= 24'h0;
            burst_left <= 5'h00;
            state <= hcdr_pkg::ST_IDLE;
        end else if (flush) begin
            active <= 1'b0;
            beats_left <= 24'h0;
            burst_left <= 5'h00;
            state <= hcdr_pkg::ST_IDLE;
        end else if (wr_cfg && wcfg.enable && !active) begin
            active <= 1'b1;
            beats_left <= next_beats;
        end else begin
            if (done) begin
                active <= 1'b0;
            end
            unique case (state)
                hcdr_pkg::ST_IDLE: begin
                    if (active && (beats_left != 24'h0) && burst_ok) begin
                        state <= hcdr_pkg::ST_BURST;
                        burst_left <= need;
                    end
                end
                hcdr_pkg::ST_BURST: begin
                    if (beat) begin
                        beats_left <= beats_left - 24'h1;
                        burst_left <= burst_left - 5'h01;
                        if (burst_left == 5'h01) begin
                            state <= hcdr_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // One RAM read is outstanding at most, and only while the FIFO has room.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fetch_left <= 24'h0;
            rd_pending <= 1'b0;
            RAM_RD_REQ <= 1'b0;
        end else if (flush) begin
            fetch_left <= 24'h0;
            rd_pending <= 1'b0;
            RAM_RD_REQ <= 1'b0;
        end else if (wr_cfg && wcfg.enable && !active) begin
            fetch_left <= wcfg.read_sel ? next_beats : 24'h0;
        end else begin
            RAM_RD_REQ <= 1'b0;
            if (RAM_RD_VALID) begin
                rd_pending <= 1'b0;
            end
            if (fetch_left != 24'h0 && !rd_pending && !RAM_RD_REQ && fifo_in_ready) begin
                RAM_RD_REQ <= 1'b1;
                rd_pending <= 1'b1;
                fetch_left <= fetch_left - 24'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data path
    assign fifo_in_valid = cfg.read_sel ? RAM_RD_VALID : beat;
    assign fifo_in_data = cfg.read_sel ? RAM_RD_DATA
        : (mode.bus32 ? din_s2 : {16'h0000, din_s2[15:0]});
    assign fifo_out_ready = cfg.read_sel ? beat : (!RAM_WR_VALID || RAM_WR_READY);

    hcdr_fifo #(
        .WIDTH(`HCDR_FIFO_WIDTH),
        .DEPTH(`HCDR_FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .flush(flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(level)
    );

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RAM_WR_VALID <= 1'b0;
            RAM_WR_DATA <= 32'h0000_0000;
        end else if (flush) begin
            RAM_WR_VALID <= 1'b0;
        end else if (!cfg.read_sel && fifo_out_ready) begin
            RAM_WR_VALID <= fifo_out_valid;
            RAM_WR_DATA <= fifo_out_data;
        end else if (RAM_WR_READY) begin
            RAM_WR_VALID <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TRANSFER_REQUEST_LINE <= 1'b1;
            DMA_DATA_OUT <= 32'h0000_0000;
            DMA_DATA_OE <= 1'b0;
            DMA_BUSY <= 1'b0;
            DMA_DONE <= 1'b0;
        end else begin
            TRANSFER_REQUEST_LINE <= ~((state == hcdr_pkg::ST_BURST)
                ^ mode.request_polarity);
            DMA_DATA_OE <= cfg.read_sel && (state == hcdr_pkg::ST_BURST);
            if (beat && cfg.read_sel) begin
                DMA_DATA_OUT <= mode.bus32 ? fifo_out_data
                    : {16'h0000, fifo_out_data[15:0]};
            end
            DMA_BUSY <= active;
            DMA_DONE <= done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    ident_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        REG_RD && REG_ADDR == `HCDR_OFS_IDENT |=> REG_RDATA == {HW_VERSION, CHIP_CODE})
        else $error("Identity read wrong");
    scratch_echo_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_scr && !soft_all |=> scratch == $past(REG_WDATA)) else $error("Scratch lost");
    hc_reset_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_rst && REG_WDATA[`HCDR_SWRST_HC_BIT] |=> HC_REG_RESET)
        else $error("Controller reset missing");
    all_reset_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_rst && REG_WDATA[`HCDR_SWRST_ALL_BIT] |=> ##1 scratch == 32'h0 && !active
        && mode.bus32) else $error("Full reset incomplete");
    beat_count_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_cfg && wcfg.enable && !active && !soft_all |=> beats_left ==
        (mode.bus32 ? 24'((25'($past(wcfg.byte_count)) + 25'h3) >> 2)
        : 24'((25'($past(wcfg.byte_count)) + 25'h1) >> 1))) else $error("Beat count wrong");
    burst_size_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        $rose(state == hcdr_pkg::ST_BURST) |-> burst_left <= burst_beats
        && burst_left != 5'h00) else $error("Burst size wrong");
    dir_path_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        beat && !cfg.read_sel |-> fifo_in_valid && !RAM_RD_REQ) else $error("Direction wrong");
    terminate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_cfg && !wcfg.enable |=> !active ##1 (TRANSFER_REQUEST_LINE
        == !mode.request_polarity)) else $error("Stop ignored");
    req_polarity_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ##1 TRANSFER_REQUEST_LINE == ($past(state == hcdr_pkg::ST_BURST)
        ~^ $past(mode.request_polarity))) else $error("Request polarity wrong");

    write_done_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        DMA_DONE && !cfg.read_sel);
    read_done_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        DMA_DONE && cfg.read_sel && !mode.bus32);
    abort_c: cover property (@(posedge REF_CLK) disable iff (!RST_N)
        (state == hcdr_pkg::ST_BURST) ##1 flush);

endmodule : hcdr_regs

`default_nettype wire

// ===== hdl/hcdr_defines.svh
/*
 * Offsets, field positions, reset values and sizes of the configuration and
 * DMA register group of the embedded host controller.
 * Assumes inclusion by bare name from the design files that need it.
 */
`ifndef HCDR_DEFINES_SVH
`define HCDR_DEFINES_SVH

`define HCDR_ADDR_W 10
`define HCDR_OFS_MODE 10'h300
`define HCDR_OFS_IDENT 10'h304
`define HCDR_OFS_SCRATCH 10'h308
`define HCDR_OFS_SWRST 10'h30C
`define HCDR_OFS_DMACFG 10'h330

`define HCDR_SWRST_ALL_BIT 0
`define HCDR_SWRST_HC_BIT 1
`define HCDR_MODE_BUS32_BIT 8
`define HCDR_MODE_ACKPOL_BIT 6
`define HCDR_MODE_REQPOL_BIT 5

`define HCDR_MODE_RESET 32'h0000_0100
`define HCDR_SCRATCH_RESET 32'h0000_0000
`define HCDR_DMACFG_RESET 32'h0000_0000

`define HCDR_FIFO_WIDTH 32
`define HCDR_FIFO_DEPTH 16
`define HCDR_LEVEL_W 5

`define HCDR_BEATS_SINGLE 5'h01
`define HCDR_BEATS_4 5'h04
`define HCDR_BEATS_8 5'h08
`define HCDR_BEATS_16 5'h10

`endif

// ===== hdl/hcdr_pkg.sv
/*
 * Types used by the register group; its transfer FIFO uses none of them.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package hcdr_pkg;

    typedef enum logic [1:0] {
        BURST_SINGLE = 2'b00,
        BURST_4 = 2'b01,
        BURST_8 = 2'b10,
        BURST_16 = 2'b11
    } hcdr_burst_t;

    typedef struct packed {
        logic [23:0] byte_count;
        logic [3:0] rsvd;
        hcdr_burst_t burst_size_sel;
        logic enable;
        logic read_sel;
    } hcdr_dma_cfg_t;

    typedef struct packed {
        logic bus32;
        logic acknowledge_polarity;
        logic request_polarity;
    } hcdr_mode_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BURST = 1'b1
    } hcdr_state_t;

endpackage : hcdr_pkg

`default_nettype wire

// ===== hdl/hcdr_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides and a fill level.
 * Assumes one clock, an active-low asynchronous reset and a synchronous flush.
 */
`default_nettype none

module hcdr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            level <= (AW+1)'(level + push - pop);
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        level <= (AW+1)'(DEPTH)) else $error("FIFO level above depth");

endmodule : hcdr_fifo

`default_nettype wire

// ===== testbench/hcdr_dma_host.sv
/*
 * Behavioural host-side DMA controller facing the register group's DMA pins.
 * Assumes the bench sets the polarities to match the mode register while clear is high.
 */
`default_nettype none

module hcdr_dma_host (
    // Clock and control
    input wire logic clk,
    input wire logic req_pol,
    input wire logic ack_pol,
    input wire logic clear,
    // DMA pins
    input wire logic req_line,
    output logic ack_line,
    output logic [31:0] data_line,
    // Observation
    output var int beats,
    output var int max_run
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////
    logic active = 1'b0;
    int hold = 0;
    int run = 0;

    assign ack_line = ~(active ^ ack_pol);

    initial begin
        beats = 0;
        max_run = 0;
        data_line = 32'h0;
    end

    // Each acknowledge stays three cycles active and five inactive, so the
    // two-stage synchroniser sees every edge and the request can drop between.
    always @(negedge clk) begin
        if (clear) begin
            active = 1'b0;
            hold = 0;
            run = 0;
            beats = 0;
            max_run = 0;
        end else if (hold > 0) begin
            hold = hold - 1;
            if (req_line !== req_pol) begin
                run = 0;
            end
        end else if (active) begin
            active = 1'b0;
            hold = 4;
            data_line = ~data_line;
        end else if (req_line === req_pol) begin
            active = 1'b1;
            hold = 2;
            data_line = 32'hA5A50000 + beats;
            beats++;
            run++;
            if (run > max_run) begin
                max_run = run;
            end
        end else begin
            run = 0;
        end
    end
endmodule : hcdr_dma_host

`default_nettype wire

// ===== testbench/test_hcdr_regs.sv
/*
 * Self-checking bench for the configuration and DMA register group.
 * Assumes the design files and the host DMA model are compiled before it.
 */
`default_nettype none

module test_hcdr_regs;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [9:0] a; logic [31:0] d; logic w; logic [31:0] e;} hcdr_row_t;
    localparam logic [15:0] VER = 16'h00A1;  // Arbitrary value.
    localparam logic [15:0] CODE = 16'h5A3C;  // Arbitrary value.
    localparam logic [31:0] ID = {VER, CODE};

    logic REF_CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
    logic RAM_WR_READY = 1'b0, RAM_RD_VALID = 1'b0, rd_pend = 1'b0, oe_seen = 1'b0;
    logic req_pol = 1'b0, ack_pol = 1'b0, clear = 1'b1;
    logic [9:0] REG_ADDR = 10'h0;
    logic [31:0] REG_WDATA = 32'h0, RAM_RD_DATA = 32'h0, rdv, last_wr;
    logic [31:0] REG_RDATA, DMA_DATA_IN, DMA_DATA_OUT, RAM_WR_DATA;
    logic REG_RVALID, HC_REG_RESET, ALL_REG_RESET, TRANSFER_REQUEST_LINE;
    logic TRANSFER_ACKNOWLEDGE_LINE, DMA_DATA_OE, RAM_WR_VALID, RAM_RD_REQ, DMA_BUSY, DMA_DONE;
    int bad_count = 0, total_checks = 0, wr_n = 0, rd_n = 0, hc_n = 0, all_n = 0;
    int beats, max_run, kept;
    int runs[4] = '{1, 4, 8, 16};
    hcdr_row_t rows[11] = '{
        '{10'h304, 32'h0, 1'b0, ID}, '{10'h308, 32'h0, 1'b0, 32'h0},
        '{10'h300, 32'h0, 1'b0, 32'h100}, '{10'h30C, 32'h0, 1'b0, 32'h0},
        '{10'h330, 32'h0, 1'b0, 32'h0}, '{10'h310, 32'h0, 1'b0, 32'h0},
        '{10'h304, 32'hFFFFFFFF, 1'b1, ID}, '{10'h310, 32'hFFFFFFFF, 1'b1, 32'h0},
        '{10'h308, 32'hA5C30F96, 1'b1, 32'hA5C30F96}, '{10'h330, 32'h200C, 1'b1, 32'h200C},
        '{10'h30C, 32'h0, 1'b1, 32'h0}};

    hcdr_regs #(.HW_VERSION(VER), .CHIP_CODE(CODE)) hcdr_regs_inst (.REF_CLK, .RST_N,
        .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .REG_RVALID, .HC_REG_RESET,
        .ALL_REG_RESET, .TRANSFER_REQUEST_LINE, .TRANSFER_ACKNOWLEDGE_LINE, .DMA_DATA_IN,
        .DMA_DATA_OUT, .DMA_DATA_OE, .RAM_WR_VALID, .RAM_WR_READY, .RAM_WR_DATA, .RAM_RD_REQ,
        .RAM_RD_VALID, .RAM_RD_DATA, .DMA_BUSY, .DMA_DONE);

    hcdr_dma_host hcdr_dma_host_inst (.clk(REF_CLK), .req_pol, .ack_pol, .clear,
        .req_line(TRANSFER_REQUEST_LINE), .ack_line(TRANSFER_ACKNOWLEDGE_LINE),
        .data_line(DMA_DATA_IN), .beats, .max_run);

    ////////////////////////////////////////////////////////////
    always #12.5 REF_CLK = ~REF_CLK;

    always @(posedge REF_CLK) begin
        if (RAM_WR_VALID && RAM_WR_READY) begin
            wr_n++;
            last_wr = RAM_WR_DATA;
        end
        if (RAM_RD_REQ) begin
            rd_n++;
            rd_pend = 1'b1;
        end
        oe_seen = oe_seen | DMA_DATA_OE;
        hc_n = hc_n + int'(HC_REG_RESET);
        all_n = all_n + int'(ALL_REG_RESET);
    end

    // The RAM stalls every other cycle so the FIFO really has to hold data.
    always @(negedge REF_CLK) begin
        RAM_WR_READY = ~RAM_WR_READY;
        RAM_RD_VALID = rd_pend;
        RAM_RD_DATA = rd_pend ? 32'h3C000000 + rd_n : ~RAM_RD_DATA;
        rd_pend = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic reg_wr(input logic [9:0] a, input logic [31:0] d);
        @(negedge REF_CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge REF_CLK);
        REG_WR = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [9:0] a, output logic [31:0] d);
        @(negedge REF_CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge REF_CLK);
        REG_RD = 1'b0;
        check({31'h0, REG_RVALID}, 32'h1, "read answer");
        d = REG_RDATA;
    endtask : reg_rd

    task automatic run_dma(input logic [31:0] mode, input logic [31:0] cfg, input int nb,
                           input int nrun);
        int i;
        clear <= 1'b1;
        reg_wr(10'h300, mode);
        req_pol <= mode[5];
        ack_pol <= mode[6];
        wr_n = 0;
        rd_n = 0;
        oe_seen = 1'b0;
        @(negedge REF_CLK);
        clear <= 1'b0;
        reg_wr(10'h330, cfg);
        for (i = 0; i < 4000 && DMA_DONE !== 1'b1; i++) @(negedge REF_CLK);
        if (i == 4000) begin
            bad_count++;
            $display("[FAIL] %0t transfer never finished", $time);
            stop_test();
        end
        repeat (2) @(negedge REF_CLK);
        check(beats, nb, "beat count");
        check(max_run, nrun, "beats per request");
        check(cfg[0] ? rd_n : wr_n, nb, "RAM words moved");
        check({31'h0, DMA_BUSY}, 32'h0, "busy after done");
        $display("test dma cfg %h done", cfg);
    endtask : run_dma

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge REF_CLK);
        check({31'h0, TRANSFER_REQUEST_LINE}, 32'h1, "request idle in reset");
        check({31'h0, DMA_BUSY}, 32'h0, "busy in reset");
        RST_N = 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].w) begin
                reg_wr(rows[i].a, rows[i].d);
            end
            reg_rd(rows[i].a, rdv);
            check(rdv, rows[i].e, "register row");
        end
        check(hc_n + all_n, 32'h0, "reset pulse without a one");
        $display("test register rows done");
        reg_wr(10'h300, 32'h60);
        reg_wr(10'h308, 32'h11);
        reg_wr(10'h30C, 32'h2);
        repeat (3) @(negedge REF_CLK);
        check(hc_n, 32'h1, "partial reset pulse");
        check(all_n, 32'h0, "full reset on partial");
        reg_rd(10'h308, rdv);
        check(rdv, 32'h11, "scratch kept by partial reset");
        reg_wr(10'h30C, 32'h1);
        repeat (3) @(negedge REF_CLK);
        check(all_n, 32'h1, "full reset pulse");
        reg_rd(10'h308, rdv);
        check(rdv, 32'h0, "scratch after full reset");
        reg_rd(10'h300, rdv);
        check(rdv, 32'h100, "mode after full reset");
        reg_rd(10'h330, rdv);
        check(rdv, 32'h0, "dma config after full reset");
        $display("test soft resets done");
        for (int b = 0; b < 4; b++) begin
            run_dma(32'h160, {24'h40, 4'h0, b[1:0], 2'b10}, 16, runs[b]);
            check(last_wr, 32'hA5A5000F, "last word into RAM");
        end
        run_dma(32'h160, {24'hA, 8'h0E}, 3, 3);
        check(last_wr, 32'hA5A50002, "last word, wide bus");
        run_dma(32'h0, {24'hA, 8'h0E}, 5, 5);
        check(last_wr, 32'h4, "last word, narrow bus");
        run_dma(32'h160, {24'h8, 8'h0F}, 2, 2);
        check({31'h0, oe_seen}, 32'h1, "data pins driven on read");
        check(wr_n, 32'h0, "no RAM writes on read");
        check(DMA_DATA_OUT, 32'h3C000002, "last word out of RAM");
        clear <= 1'b1;
        @(negedge REF_CLK);
        clear <= 1'b0;
        reg_wr(10'h330, {24'h400, 8'h0E});
        repeat (40) @(negedge REF_CLK);
        check({31'h0, DMA_BUSY}, 32'h1, "busy before abort");
        reg_wr(10'h330, 32'h0);
        repeat (4) @(negedge REF_CLK);
        kept = beats;
        check({31'h0, DMA_BUSY}, 32'h0, "busy after abort");
        check({31'h0, beats < 256}, 32'h1, "abort cut the transfer");
        repeat (40) @(negedge REF_CLK);
        check(beats, kept, "beats after abort");
        $display("test abort done");
        stop_test();
    end
endmodule : test_hcdr_regs

`default_nettype wire
